// ---- dv/csa_fe_model.sv ----
// Behavioural converter front end for the sense block.
// Assumes one-cycle conv_start pulses from the block.
`default_nettype none
module csa_fe_model #(parameter int DLY = 12) (
  input  wire logic        sys_clk,    // System clock
  input  wire logic [15:0] base,       // Mean sample value
  input  wire logic [15:0] swing,      // Alternating offset
  input  wire logic        conv_start, // Conversion request
  output var  logic        conv_valid, // One-cycle result strobe
  output var  logic [15:0] conv_data   // Result, valid with strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int   left = 0;    // Cycles until the answer
  logic odd  = 1'b0; // Picks the sign of the offset
  initial begin
    conv_valid = 1'b0;
    conv_data  = 16'h0000;
  end
  // Answer after DLY cycles; between strobes the data bus shows junk
  // so a design sampling it outside the strobe gets a wrong sum
  always @(posedge sys_clk) begin
    conv_valid <= 1'b0;
    conv_data  <= ~conv_data;
    if (conv_start)
      left <= DLY;
    else if (left != 0) begin
      left <= left - 1;
      if (left == 1) begin
        conv_valid <= 1'b1;
        conv_data  <= odd ? base + swing : base - swing;
        odd        <= !odd;
      end
    end
  end
endmodule // csa_fe_model
`default_nettype wire

// ---- dv/csa_top_assertions.sv ----
// Port-level checker for the sense control block.
// Assumes the hand-over timing: one wait state, registered read data.
`default_nettype none
module csa_top_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        conv_valid,
  input wire logic        conv_start,
  input wire logic        sense_powered,
  input wire logic [3:0]  channel_mux_select,
  input wire logic        irq
);
  logic       pend;    // A conversion is outstanding
  logic [3:0] since_v; // Cycles since the last sample, saturating
  // Track outstanding request and age of the last sample
  always @(posedge sys_clk) begin
    if (rst || conv_valid)
      pend <= 1'b0;
    else if (conv_start)
      pend <= 1'b1;
    if (rst)
      since_v <= 4'hF;
    else if (conv_valid)
      since_v <= 4'h0;
    else if (since_v != 4'hF)
      since_v <= since_v + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_new_req;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_ctl_wr;
    avs_write && avs_waitrequest && avs_address == 8'hB0;
  endsequence
  a_wait_first: assert property (s_new_req |-> avs_waitrequest)
    else $error("no wait state on new request");
  a_wait_once: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_enable_power: assert property
    (s_ctl_wr |=> sense_powered == $past(avs_writedata[7]))
    else $error("power does not follow enable bit");
  a_idle_no_start: assert property (!sense_powered |-> !conv_start)
    else $error("conversion requested while disabled");
  a_unused_zero: assert property
    (avs_read && !avs_waitrequest && avs_address == 8'hB0
     |-> avs_readdata[6] == 1'b0 && avs_readdata[2:1] == 2'b00)
    else $error("unused control bits read nonzero");
  a_one_pending: assert property (conv_start |-> !pend)
    else $error("second request while one outstanding");
  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> !sense_powered && !irq && channel_mux_select == 4'h0)
    else $error("outputs not cleared by reset");
  a_mux_cause: assert property ($changed(channel_mux_select)
    |-> since_v <= 4'h6 || $past(avs_write && avs_address == 8'hC0))
    else $error("channel moved without a cause");
  a_mask_quiet: assert property (avs_write && avs_waitrequest &&
    avs_address == 8'hCC && avs_writedata[1:0] == 2'b00 |=> !irq)
    else $error("interrupt high with all masked");
endmodule // csa_top_assertions
bind csa_top csa_top_assertions i_chk (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .conv_valid(conv_valid), .conv_start(conv_start),
  .sense_powered(sense_powered),
  .channel_mux_select(channel_mux_select), .irq(irq));
`default_nettype wire

// ---- dv/csa_top_tb.sv ----
// Self-checking bench for the sense control block.
// Assumes the front end model answers each request after 12 cycles.
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module csa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, x;
  logic        avs_waitrequest, ext_start = 1'b0, conv_valid;
  logic        conv_start, sense_powered, irq;
  logic [15:0] conv_data, base = 16'h1234, swing = 16'h0000;
  logic [3:0]  channel_mux_select, mq[$];
  int n_errors = 0, num_checks = 0, n_st = 0, n1, cyc = 0;
  int cnt[6] = '{1, 4, 8, 16, 32, 64};
  logic [2:0] md[3] = '{3'h0, 3'h6, 3'h7}; // Modes that take a write
  logic [3:0] exp_ch[4] = '{4'h3, 4'h4, 4'h2, 4'h3};
  csa_top i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_start(ext_start),
    .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_start(conv_start), .sense_powered(sense_powered),
    .channel_mux_select(channel_mux_select), .irq(irq));
  csa_fe_model i_fe (.sys_clk(sys_clk), .base(base), .swing(swing),
    .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_data(conv_data));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Count requests, note the channel of each, and bound the run
  always @(posedge sys_clk) begin
    cyc++;
    if (conv_start === 1'b1) begin
      n_st++;
      mq.push_back(channel_mux_select);
    end
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus cycle: hold until waitrequest is seen low, then release
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, x);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0, x);
    `CHK(nm, e, x)
  endtask
  task automatic wait_irq;
    while (irq !== 1'b1) @(negedge sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rc("ctl", 8'hB0, 32'h0);
    rc("unmapped", 8'hF0, 32'h0); // Unmapped place reads zero
    wr(8'hCC, 32'h3);
    wr(8'hB0, 32'hCE);
    rc("ctl bits", 8'hB0, 32'h88);
    wr(8'hBC, 32'h8000);
    for (int i = 0; i < 6; i++) begin
      swing <= (i == 0) ? 16'h0000 : 16'h0100;
      wr(8'hB4, {24'h0, md[i % 3], 2'b01, i[2:0]});
      n_st = 0;
      wr(8'hB0, 32'h98);
      rc("busy", 8'hB0, 32'h98);
      wr(8'hB0, 32'h98);
      wait_irq();
      `CHK("starts", cnt[i], n_st)
      rc("result", 8'hB8, 32'h1234);
      rc("done", 8'hB0, 32'hA8);
      rc("status", 8'hC8, 32'h1);
      wr(8'hC8, 32'h3);
      wr(8'hB0, 32'h88);
      `CHK("irq clr", 1'b0, irq)
    end
    $display("test counts done");
    wr(8'hB4, 32'h20);
    wr(8'hBC, 32'h0100);
    n_st = 0;
    wr(8'hB0, 32'h98);
    repeat (20) @(posedge sys_clk);
    `CHK("refused", 0, n_st)
    ext_start <= 1'b1;
    @(posedge sys_clk);
    ext_start <= 1'b0;
    wait_irq();
    repeat (2) @(posedge sys_clk);
    rc("greater", 8'hC8, 32'h3);
    rc("cmp flag", 8'hB0, 32'hA9);
    wr(8'hB0, 32'h88);
    rc("flag ro", 8'hB0, 32'h89);
    $display("test start modes done");
    wr(8'hC8, 32'h3);
    wr(8'hCC, 32'h2);
    wr(8'hC4, 32'h42);
    wr(8'hC0, 32'h3);
    wr(8'hBC, 32'h8000);
    wr(8'hB4, 32'h10);
    mq.delete();
    n_st = 0;
    wr(8'hB0, 32'h98);
    while (n_st < 4) @(negedge sys_clk);
    for (int k = 0; k < 4; k++)
      `CHK("chan", exp_ch[k], mq[k])
    wr(8'hBC, 32'h0);
    wait_irq();
    n1 = n_st;
    repeat (40) @(posedge sys_clk);
    `CHK("scan stop", n1, n_st)
    `CHK("mux held", mq[$], channel_mux_select)
    $display("test scan done");
    wr(8'hCC, 32'h0);
    `CHK("masked", 1'b0, irq)
    wr(8'hB0, 32'h0);
    `CHK("power", 1'b0, sense_powered)
    $display("test disable done");
    tally_and_finish();
  end
endmodule // csa_top_tb
`default_nettype wire

// ---- rtl/csa_accum.v ----
// Sample accumulator: sums conversions and scales the sum to 16 bits.
// Assumes one-cycle sample strobes from the converter front end.
`include "csa_defs.vh"
`default_nettype none

module csa_accum (
  input  wire        sys_clk,     // System clock
  input  wire        rst,         // Synchronous reset, active high
  input  wire        clear,       // Start a fresh set
  input  wire        sample_vld,  // Raw conversion strobe
  input  wire [15:0] sample,      // Raw conversion value
  input  wire [2:0]  acu_sel,     // Accumulate count select
  output reg         set_done,    // One-cycle pulse, set complete
  output reg  [15:0] set_result   // Scaled result
);

  reg  [21:0] sum_reg;            // Running sum
  reg  [6:0]  cnt_reg;            // Samples taken in the set
  reg  [6:0]  target;             // Count for this selection
  reg  [2:0]  shift;              // Divide as a right shift
  wire [21:0] sum_next;           // Sum including this sample
  wire [21:0] scaled;             // Sum divided by the count

  assign sum_next = sum_reg + {6'h00, sample};
  // The divided sum of a full set never exceeds 16 bits
  assign scaled   = sum_next >> shift;

  ////////////////////////////////////////////////////////////////////
  // Decode count; codes above five fall back to 64 samples
  always @* begin
    case (acu_sel)
      3'h0:    begin target = 7'h01; shift = 3'h0; end
      3'h1:    begin target = 7'h04; shift = 3'h2; end
      3'h2:    begin target = 7'h08; shift = 3'h3; end
      3'h3:    begin target = 7'h10; shift = 3'h4; end
      3'h4:    begin target = 7'h20; shift = 3'h5; end
      default: begin target = 7'h40; shift = 3'h6; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Sum samples; a 64x16 sum fits 22 bits exactly
  always @(posedge sys_clk) begin
    set_done <= 1'b0;
    if (rst || clear) begin
      sum_reg <= 22'h000000;
      cnt_reg <= 7'h00;
      if (rst) begin
        set_result <= 16'h0000;
      end
    end else if (sample_vld) begin
      if (cnt_reg + 7'h01 == target) begin
        set_result <= scaled[15:0];
        set_done   <= 1'b1;
        sum_reg    <= 22'h000000;
        cnt_reg    <= 7'h00;
      end else begin
        sum_reg <= sum_next;
        cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end

endmodule // csa_accum
`default_nettype wire

// ---- rtl/csa_defs.vh ----
// Constants for the capacitive-sense accumulator and control block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
// Contract
// - Accumulate 1,4,8,16,32 or 64 conversions
// - Divide 22-bit sum by count to 16 bits
// - Done flag after each result set
// - Accumulated result compared after full count
// - Single result compared after each conversion
// - Greater result stops scan, mux stays
// - Otherwise advance mux, wrap end to start
// - Bit 7 enables unit, clear means idle
// - Bit 5 done flag, software clears only; the code also sets it on a written one
// - Bit 4 reads one while converting
// - Writing one starts in modes 000,110,111
// - Bit 3 enables the digital comparator
// - Bit 0 sticky greater-than flag
// - Bits 6,2,1 read zero, writes ignored
// - Control at 0xB0, all bits reset zero
`ifndef CSA_DEFS_VH
`define CSA_DEFS_VH

// Register byte addresses
`define CSA_ADDR_CONTROL   8'hB0
`define CSA_ADDR_CONFIG    8'hB4
`define CSA_ADDR_RESULT    8'hB8
`define CSA_ADDR_THRESHOLD 8'hBC
`define CSA_ADDR_MUX       8'hC0
`define CSA_ADDR_SCAN      8'hC4
`define CSA_ADDR_IRQ_STAT  8'hC8
`define CSA_ADDR_IRQ_MASK  8'hCC

// Control register bit positions
`define CSA_CTL_ENABLE     7
`define CSA_CTL_DONE       5
`define CSA_CTL_BUSY       4
`define CSA_CTL_CMPEN      3
`define CSA_CTL_CMPF       0
`define CSA_CTL_WMASK      8'hB9
`define CSA_CTL_RESET      8'h00

// Config register fields
`define CSA_CFG_ACU_LSB    0
`define CSA_CFG_ACCEN      3
`define CSA_CFG_SCANEN     4
`define CSA_CFG_MODE_LSB   5
`define CSA_CFG_RESET      8'h00

// Start modes that accept a busy-bit write
`define CSA_MODE_SW0       3'h0
`define CSA_MODE_SW6       3'h6
`define CSA_MODE_SW7       3'h7

// Widths
`define CSA_ACC_W          22
`define CSA_RES_W          16
`define CSA_CH_W           4

// Interrupt status bits
`define CSA_IRQ_DONE       0
`define CSA_IRQ_GREATER    1

`endif

// ---- rtl/csa_scan.v ----
// Channel multiplexer stepper for auto-scan.
// Assumes a one-cycle step strobe after each judged result.
`include "csa_defs.vh"
`default_nettype none

module csa_scan (
  input  wire       sys_clk,     // System clock
  input  wire       rst,         // Synchronous reset, active high
  input  wire       load,        // Software write to the mux
  input  wire [3:0] load_val,    // Value written
  input  wire       step,        // Result judged
  input  wire       scan_en,     // Auto-scan on
  input  wire       greater,     // Result above threshold
  input  wire [3:0] scan_start,  // First channel
  input  wire [3:0] scan_end,    // Last channel
  output reg  [3:0] mux_sel,     // Current channel
  output reg        scan_stop    // One-cycle pulse, scan halted
);

  ////////////////////////////////////////////////////////////////////
  // Advance, hold or wrap the channel
  always @(posedge sys_clk) begin
    scan_stop <= 1'b0;
    if (rst) begin
      mux_sel <= 4'h0;
    end else if (load) begin
      mux_sel <= load_val;
    end else if (step && scan_en) begin
      if (greater) begin
        scan_stop <= 1'b1;
      end else if (mux_sel == scan_end) begin
        mux_sel <= scan_start;
      end else begin
        mux_sel <= mux_sel + 4'h1;
      end
    end
  end

endmodule // csa_scan
`default_nettype wire

// ---- rtl/csa_top.v ----
// Capacitive-sense control, accumulator, comparator and scan top.
// Assumes an Avalon-MM master and a converter front end that returns
// one sample strobe per requested conversion while enabled.
//
// Local design decision: the Avalon-MM interface to the registers.
`include "csa_defs.vh"
`default_nettype none

module csa_top (
  input  wire        sys_clk,          // System clock, 200 MHz
  input  wire        rst,              // Synchronous reset, active high
  input  wire [7:0]  avs_address,      // Byte address
  input  wire        avs_read,         // Read request
  input  wire        avs_write,        // Write request
  input  wire [31:0] avs_writedata,    // Write data
  input  wire [3:0]  avs_byteenable,   // Byte enables
  output reg  [31:0] avs_readdata,     // Read data
  output wire        avs_waitrequest,  // Wait request
  input  wire        ext_start,        // Hardware start trigger
  input  wire        conv_valid,       // Front end finished a conversion
  input  wire [15:0] conv_data,        // Front end raw value
  output wire        conv_start,       // Request one conversion
  output wire        sense_powered,    // Front end out of low power
  output wire [3:0]  channel_mux_select, // Selected electrode
  output wire        irq               // Level interrupt
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  capsense_control_reg;  // Control, low byte
  reg  [7:0]  capsense_config_reg;   // Count, accumulate, scan, mode
  reg  [15:0] threshold_reg;         // Greater-than threshold
  reg  [15:0] result_reg;            // Latest scaled result
  reg  [7:0]  scan_reg;              // End in [7:4], start in [3:0]
  reg  [1:0]  irq_stat_reg;          // Sticky events
  reg  [1:0]  irq_mask_reg;          // Event enables
  reg         ack_reg;               // Answer phase of an access
  reg         busy_reg;              // Set in progress
  reg         req_reg;               // Conversion request pulse
  reg         smp_seen_reg;          // A sample of the set came in

  wire        en      = capsense_control_reg[`CSA_CTL_ENABLE];
  wire        cmpen   = capsense_control_reg[`CSA_CTL_CMPEN];
  wire        acc_en  = capsense_config_reg[`CSA_CFG_ACCEN];
  wire        scan_en = capsense_config_reg[`CSA_CFG_SCANEN];
  wire [2:0]  mode    = capsense_config_reg[7:5];
  wire [2:0]  acu     = acc_en ? capsense_config_reg[2:0] : 3'h0;

  wire        wr_hit  = avs_write && !ack_reg;  // Write taken once
  wire        wr_ctl  = wr_hit && avs_address == `CSA_ADDR_CONTROL &&
                        avs_byteenable[0];
  wire        wr_cfg  = wr_hit && avs_address == `CSA_ADDR_CONFIG &&
                        avs_byteenable[0];
  wire        wr_mux  = wr_hit && avs_address == `CSA_ADDR_MUX &&
                        avs_byteenable[0];

  wire        set_done;     // Accumulation set finished
  wire [15:0] set_result;   // Scaled value from accumulator
  wire        scan_stop;    // Unused; u_scan leaves its scan_stop port open
  wire        greater;      // Result above threshold

  ////////////////////////////////////////////////////////////////////
  // One wait state: waitrequest drops in the cycle after the request
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always @(posedge sys_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Start decode: software start only in modes 000, 110, 111
  wire sw_mode  = mode == `CSA_MODE_SW0 || mode == `CSA_MODE_SW6 ||
                  mode == `CSA_MODE_SW7;
  wire sw_start = wr_ctl && avs_writedata[`CSA_CTL_BUSY] && sw_mode;
  wire hw_start = ext_start && !sw_mode;
  wire start    = en && !busy_reg && (sw_start || hw_start);

  // Auto-scan keeps converting until a greater result with cmpen set stops it
  wire rescan   = set_done && scan_en && !(cmpen && greater);

  assign greater = set_result > threshold_reg;

  ////////////////////////////////////////////////////////////////////
  // Busy and conversion requests; one request per expected sample.
  // The next request waits one cycle after a sample so that set_done
  // is known first; otherwise the last sample of a set would ask for
  // one conversion too many.
  always @(posedge sys_clk) begin
    req_reg      <= 1'b0;
    smp_seen_reg <= 1'b0;
    if (rst || !en) begin
      busy_reg <= 1'b0;
    end else begin
      smp_seen_reg <= busy_reg && conv_valid;
      if (start) begin
        busy_reg <= 1'b1;
        req_reg  <= 1'b1;
      end else if (set_done) begin
        busy_reg <= rescan;
        req_reg  <= rescan;
      end else if (smp_seen_reg) begin
        req_reg  <= 1'b1;  // Next sample of the set
      end
    end
  end

  // No request leaves a disabled unit, even in the cycle of the write
  assign conv_start    = req_reg && en;
  assign sense_powered = en;

  ////////////////////////////////////////////////////////////////////
  // Accumulator and scan stepper
  csa_accum u_accum (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clear      (start || !en),
    .sample_vld (conv_valid && busy_reg),
    .sample     (conv_data),
    .acu_sel    (acu),
    .set_done   (set_done),
    .set_result (set_result)
  );

  csa_scan u_scan (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .load       (wr_mux),
    .load_val   (avs_writedata[3:0]),
    .step       (set_done),
    .scan_en    (scan_en),
    .greater    (cmpen && greater),
    .scan_start (scan_reg[3:0]),
    .scan_end   (scan_reg[7:4]),
    .mux_sel    (channel_mux_select),
    .scan_stop  ()
  );

  ////////////////////////////////////////////////////////////////////
  // Control register: done flag set over clear, compare flag cleared only by reset
  always @(posedge sys_clk) begin
    if (rst) begin
      capsense_control_reg <= `CSA_CTL_RESET;
    end else begin
      if (wr_ctl) begin
        capsense_control_reg[`CSA_CTL_ENABLE] <= avs_writedata[7];
        capsense_control_reg[`CSA_CTL_CMPEN]  <= avs_writedata[3];
        capsense_control_reg[`CSA_CTL_DONE]   <= avs_writedata[5];
      end
      if (set_done) begin
        capsense_control_reg[`CSA_CTL_DONE] <= 1'b1;
      end
      if (set_done && cmpen && greater) begin
        capsense_control_reg[`CSA_CTL_CMPF] <= 1'b1;
      end
      capsense_control_reg[`CSA_CTL_BUSY] <= 1'b0;
      capsense_control_reg[6]             <= 1'b0;
      capsense_control_reg[2:1]           <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration, threshold, scan range and result
  always @(posedge sys_clk) begin
    if (rst) begin
      capsense_config_reg <= `CSA_CFG_RESET;
      threshold_reg       <= 16'h0000;
      scan_reg            <= 8'h00;
      result_reg          <= 16'h0000;
    end else begin
      if (wr_cfg) begin
        capsense_config_reg <= avs_writedata[7:0];
      end
      if (wr_hit && avs_address == `CSA_ADDR_THRESHOLD) begin
        if (avs_byteenable[0]) begin
          threshold_reg[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          threshold_reg[15:8] <= avs_writedata[15:8];
        end
      end
      if (wr_hit && avs_address == `CSA_ADDR_SCAN && avs_byteenable[0]) begin
        scan_reg <= avs_writedata[7:0];
      end
      if (set_done) begin
        result_reg <= set_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins
  wire [1:0] irq_set = {set_done && cmpen && greater, set_done};
  wire [1:0] irq_clr = (wr_hit && avs_address == `CSA_ADDR_IRQ_STAT &&
                        avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

  always @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_hit && avs_address == `CSA_ADDR_IRQ_MASK &&
          avs_byteenable[0]) begin
        irq_mask_reg <= avs_writedata[1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        `CSA_ADDR_CONTROL:   avs_readdata <= {24'h000000,
                               capsense_control_reg[7:5], busy_reg,
                               capsense_control_reg[3:0]};
        `CSA_ADDR_CONFIG:    avs_readdata <= {24'h000000, capsense_config_reg};
        `CSA_ADDR_RESULT:    avs_readdata <= {16'h0000, result_reg};
        `CSA_ADDR_THRESHOLD: avs_readdata <= {16'h0000, threshold_reg};
        `CSA_ADDR_MUX:       avs_readdata <= {28'h0000000, channel_mux_select};
        `CSA_ADDR_SCAN:      avs_readdata <= {24'h000000, scan_reg};
        `CSA_ADDR_IRQ_STAT:  avs_readdata <= {30'h00000000, irq_stat_reg};
        `CSA_ADDR_IRQ_MASK:  avs_readdata <= {30'h00000000, irq_mask_reg};
        default:             avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule // csa_top
`default_nettype wire
